// ---- core/pfsa_ctrl.sv ----
// Purpose: Program flash self-access controller: indirect reads, register
//          reads, row erase, latch loads and row programming.
// Assumes: APB slave with one access cycle; flash array returns read data
//          in the cycle after the rd strobe.
// Notes:   The core is stalled through o_core_stall while busy.
//
// Overview of operation
// R1: Pointer bit 15 high selects flash.
// R2: Pointer at data port reads zero.
// R3: Indirect read stalls briefly, returns one byte.
// R4: Indirect stores never write or erase.
// R5: Write-protect blocks register writes and erases.
// R6: Software sets region, address, then read.
// R7: Read stalls core, data lands next cycle.
// R8: Data pair holds until read or write.
// R9: Read start bit clears itself.
// R10: Unlock is 55h, AAh, then write start.
// R11: Erase or program needs completed unlock.
// R12: Core stalls until operation finishes.
// R13: Disturbed unlock performs no action.
// R14: Software masks interrupts around unlock.
// R15: Erase setup: region, address, erase, enable.
// R16: Protected target clears write start, no erase.
// R17: Erase done sets flag, interrupt if enabled.
// R18: Erase keeps latches and write enable.
// R19: High bits pick row, low five latch.
// R20: Program completion blanks all latches.
// R21: Latch-only mode loads; otherwise programs row.
// R22: Software erases before programming.
// R23: Software modifies rows via RAM image.
// R24: Error flag on protect, reset, broken unlock.
// R25: Invalid region read clears data pair.
// R26: Internal timer sets operation length.
`timescale 1ns/100ps
`include "pfsa_defs.svh"
module pfsa_ctrl #(
  parameter int OP_CYCLES = `PFSA_T_OP_US * `PFSA_CLK_MHZ
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire pfsa_pkg::pfsa_ind_req_s i_ind,
  output logic [7:0] o_ind_data,
  output logic o_ind_valid,
  output logic o_core_stall,
  input wire logic i_seq_disturb,
  input wire logic i_write_protect,
  output pfsa_pkg::pfsa_flash_req_s o_flash,
  input wire logic [13:0] i_fl_rdata,
  output logic o_done_irq
);
  pfsa_pkg::pfsa_state_e state_reg;
  pfsa_pkg::pfsa_key_e key_reg;
  logic [14:0] adr_reg;
  logic [13:0] data_reg;
  logic [6:0] ctrl_reg;
  logic stat_done_reg;
  logic stat_ie_reg;
  logic ind_src_reg;
  logic [4:0] widx_reg;
  logic is_prog_reg;
  logic setup;
  logic mapped;
  logic wr_acc;
  logic key_wr;
  logic ctrl_wr;
  logic step_ok;
  logic seq_break;
  logic go_wr;
  logic go_rd;
  logic go_erase;
  logic go_prog;
  logic go_latch;
  logic wr_err;
  logic wr_blocked;
  logic rd_valid;
  logic ptr_port;
  logic tmr_start;
  logic tmr_done;
  logic op_end;
  logic rd_take;
  logic [13:0] latch_rdata;
  logic [31:0] rmux;

  // Region-one addresses that hold readable words.
  function automatic logic rd_ok(input logic regs, input logic [14:0] a);
    if (!regs) begin
      rd_ok = 1'b1;
    end else begin
      rd_ok = (a <= 15'h0003) || (a >= 15'h0005 && a <= 15'h000b) ||
              (a >= 15'h0100 && a <= 15'h02ff);
    end
  endfunction

  // Only user IDs and configuration words accept writes in region one.
  function automatic logic wr_prot(input logic regs, input logic [14:0] a,
                                   input logic wp);
    wr_prot = wp || (regs && !((a <= 15'h0003) ||
              (a >= 15'h0007 && a <= 15'h000b)));
  endfunction

  // APB decode; writes take effect in the access phase with pready high.
  assign setup = i_psel && !i_penable;
  assign mapped = (i_paddr == `PFSA_OFF_ADDR) || (i_paddr == `PFSA_OFF_DATA)
               || (i_paddr == `PFSA_OFF_CTRL) || (i_paddr == `PFSA_OFF_KEY)
               || (i_paddr == `PFSA_OFF_STAT);
  assign wr_acc = i_psel && i_penable && i_pwrite && o_pready;
  assign key_wr = wr_acc && (i_paddr == `PFSA_OFF_KEY);
  assign ctrl_wr = wr_acc && (i_paddr == `PFSA_OFF_CTRL);

  // Unlock tracking: any other bus write or a disturbance breaks it.
  always_comb begin
    unique case (key_reg)
      pfsa_pkg::KEY_ONE: step_ok = key_wr &&
                           (i_pwdata[7:0] == `PFSA_KEY_SECOND);
      pfsa_pkg::KEY_TWO: step_ok = ctrl_wr && i_pwdata[`PFSA_CTRL_WR];
      default: step_ok = 1'b0;
    endcase
  end
  assign seq_break = (key_reg != pfsa_pkg::KEY_NONE) &&
                     (i_seq_disturb || (wr_acc && !step_ok)); // R13

  // Operation launch; the written control value selects the action.
  assign go_wr = (key_reg == pfsa_pkg::KEY_TWO) && step_ok && // R10
                 !i_seq_disturb && i_pwdata[`PFSA_CTRL_WRITE_ENABLE_BIT] &&
                 (state_reg == pfsa_pkg::ST_IDLE);
  assign wr_blocked = wr_prot(i_pwdata[`PFSA_CTRL_REGS], adr_reg,
                              i_write_protect); // R5
  assign go_erase = go_wr && i_pwdata[`PFSA_CTRL_FREE] && !wr_blocked; // R11
  assign go_prog = go_wr && !i_pwdata[`PFSA_CTRL_FREE] &&
                   !i_pwdata[`PFSA_CTRL_LATCH_ONLY_MODE] && !wr_blocked; // R21
  assign go_latch = go_wr && !i_pwdata[`PFSA_CTRL_FREE] &&
                    i_pwdata[`PFSA_CTRL_LATCH_ONLY_MODE]; // R21
  assign wr_err = go_wr && wr_blocked && !go_latch; // R16
  assign go_rd = ctrl_wr && i_pwdata[`PFSA_CTRL_RD] && !go_wr &&
                 (state_reg == pfsa_pkg::ST_IDLE);
  assign rd_valid = rd_ok(i_pwdata[`PFSA_CTRL_REGS], adr_reg);
  assign ptr_port = (i_ind.ptr == `PFSA_IND_PORT0) ||
                    (i_ind.ptr == `PFSA_IND_PORT1);
  assign tmr_start = (go_erase && !i_seq_disturb) ||
                     (state_reg == pfsa_pkg::ST_PROG &&
                      widx_reg == `PFSA_LAST_LATCH); // R26
  assign op_end = (state_reg == pfsa_pkg::ST_WAIT) && tmr_done;
  assign rd_take = (state_reg == pfsa_pkg::ST_RD_TAKE) && !ind_src_reg;

  // APB answer: registered in setup so the access phase ends at once.
  always_comb begin
    unique case (i_paddr)
      `PFSA_OFF_ADDR: rmux = {17'h0, adr_reg};
      `PFSA_OFF_DATA: rmux = {18'h0, data_reg};
      `PFSA_OFF_CTRL: rmux = {25'h0, ctrl_reg};
      `PFSA_OFF_STAT: rmux = {30'h0, stat_ie_reg, stat_done_reg};
      default: rmux = 32'h0;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0;
    end else begin
      o_pready <= setup;
      o_pslverr <= setup && !mapped;
      if (setup && !i_pwrite) begin
        o_prdata <= rmux;
      end
    end
  end

  // Unlock key state; a breaking 55h restarts the count.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      key_reg <= pfsa_pkg::KEY_NONE;
    end else if (seq_break || (key_reg == pfsa_pkg::KEY_TWO && step_ok)) begin
      key_reg <= (key_wr && !i_seq_disturb &&
                  i_pwdata[7:0] == `PFSA_KEY_FIRST) ?
                 pfsa_pkg::KEY_ONE : pfsa_pkg::KEY_NONE; // R13
    end else if (key_reg == pfsa_pkg::KEY_ONE && step_ok) begin
      key_reg <= pfsa_pkg::KEY_TWO; // R10
    end else if (key_reg == pfsa_pkg::KEY_NONE && key_wr &&
                 !i_seq_disturb && i_pwdata[7:0] == `PFSA_KEY_FIRST) begin
      key_reg <= pfsa_pkg::KEY_ONE; // R10
    end
  end

  // Address register; the core is stalled while it is in use.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      adr_reg <= `PFSA_RST_ADDR;
    end else if (wr_acc && i_paddr == `PFSA_OFF_ADDR) begin
      adr_reg <= i_pwdata[14:0];
    end
  end

  // Data pair changes only on a read result or a software write.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      data_reg <= `PFSA_RST_DATA;
    end else if (wr_acc && i_paddr == `PFSA_OFF_DATA) begin
      data_reg <= i_pwdata[13:0]; // R8
    end else if (go_rd && !rd_valid) begin
      data_reg <= 14'h0; // R25
    end else if (rd_take) begin
      data_reg <= i_fl_rdata; // R7
    end
  end

  // Control register. A reset during a self-write leaves the error flag
  // set so software can tell the row is suspect; hardware sets win.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ctrl_reg <= `PFSA_RST_CTRL;
      ctrl_reg[`PFSA_CTRL_WRITE_ERROR_FLAG] <= (state_reg == pfsa_pkg::ST_PROG) ||
                                    (state_reg == pfsa_pkg::ST_WAIT); // R24
    end else begin
      if (ctrl_wr) begin
        ctrl_reg[`PFSA_CTRL_REGS] <= i_pwdata[`PFSA_CTRL_REGS];
        ctrl_reg[`PFSA_CTRL_LATCH_ONLY_MODE] <= i_pwdata[`PFSA_CTRL_LATCH_ONLY_MODE];
        ctrl_reg[`PFSA_CTRL_FREE] <= i_pwdata[`PFSA_CTRL_FREE];
        ctrl_reg[`PFSA_CTRL_WRITE_ENABLE_BIT] <= i_pwdata[`PFSA_CTRL_WRITE_ENABLE_BIT];
        ctrl_reg[`PFSA_CTRL_WRITE_ERROR_FLAG] <= i_pwdata[`PFSA_CTRL_WRITE_ERROR_FLAG];
      end
      if (go_rd && rd_valid) begin
        ctrl_reg[`PFSA_CTRL_RD] <= 1'b1;
      end else if (rd_take) begin
        ctrl_reg[`PFSA_CTRL_RD] <= 1'b0; // R9
      end
      if (go_erase || go_prog) begin
        ctrl_reg[`PFSA_CTRL_WR] <= 1'b1;
      end else if (op_end || wr_err) begin
        ctrl_reg[`PFSA_CTRL_WR] <= 1'b0; // R16
      end
      if (wr_err || seq_break) begin
        ctrl_reg[`PFSA_CTRL_WRITE_ERROR_FLAG] <= 1'b1; // R24
      end
    end
  end

  // Status: done flag is write-one-to-clear, completion wins the race.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      stat_done_reg <= 1'b0;
      stat_ie_reg <= 1'b0;
      o_done_irq <= 1'b0;
    end else begin
      o_done_irq <= stat_done_reg && stat_ie_reg; // R17
      if (wr_acc && i_paddr == `PFSA_OFF_STAT) begin
        stat_ie_reg <= i_pwdata[`PFSA_STAT_IE];
        if (i_pwdata[`PFSA_STAT_DONE]) begin
          stat_done_reg <= 1'b0;
        end
      end
      if (op_end) begin
        stat_done_reg <= 1'b1; // R17
      end
    end
  end

  // Sequencer: reads, erase, row programming and the core stall.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_reg <= pfsa_pkg::ST_IDLE;
      o_core_stall <= 1'b0;
      o_flash <= '0;
      o_ind_valid <= 1'b0;
      o_ind_data <= 8'h00;
      ind_src_reg <= 1'b0;
      widx_reg <= 5'h00;
      is_prog_reg <= 1'b0;
    end else begin
      o_flash.rd <= 1'b0;
      o_flash.erase <= 1'b0;
      o_flash.prog <= 1'b0;
      o_ind_valid <= 1'b0;
      unique case (state_reg)
        pfsa_pkg::ST_IDLE: begin
          if (go_erase && !i_seq_disturb) begin
            o_flash.erase <= 1'b1;
            o_flash.addr <= {i_pwdata[`PFSA_CTRL_REGS],
                             adr_reg[13:5],
                             5'h00}; // R19
            is_prog_reg <= 1'b0;
            o_core_stall <= 1'b1; // R12
            state_reg <= pfsa_pkg::ST_WAIT;
          end else if (go_prog && !i_seq_disturb) begin
            widx_reg <= 5'h00;
            is_prog_reg <= 1'b1;
            o_core_stall <= 1'b1; // R12
            state_reg <= pfsa_pkg::ST_PROG;
          end else if (go_rd && rd_valid) begin
            o_flash.rd <= 1'b1;
            o_flash.addr <= {i_pwdata[`PFSA_CTRL_REGS], adr_reg[13:0]};
            ind_src_reg <= 1'b0;
            o_core_stall <= 1'b1; // R7
            state_reg <= pfsa_pkg::ST_RD_ISSUE;
          end else if (i_ind.req && !i_ind.store) begin // R4
            if (i_ind.ptr[`PFSA_PTR_FLASH_BIT]) begin
              o_flash.rd <= 1'b1;
              o_flash.addr <= i_ind.ptr[14:0]; // R1
              ind_src_reg <= 1'b1;
              o_core_stall <= 1'b1; // R3
              state_reg <= pfsa_pkg::ST_RD_ISSUE;
            end else begin
              o_ind_valid <= 1'b1;
              o_ind_data <= 8'h00; // R2
            end
          end
        end
        pfsa_pkg::ST_RD_ISSUE: begin
          state_reg <= pfsa_pkg::ST_RD_TAKE;
        end
        pfsa_pkg::ST_RD_TAKE: begin
          o_core_stall <= 1'b0; // R3
          state_reg <= pfsa_pkg::ST_IDLE;
          if (ind_src_reg) begin
            o_ind_valid <= 1'b1;
            o_ind_data <= i_fl_rdata[7:0]; // R3
          end
        end
        pfsa_pkg::ST_PROG: begin
          o_flash.prog <= 1'b1;
          o_flash.addr <= {ctrl_reg[`PFSA_CTRL_REGS], adr_reg[13:5],
                           widx_reg}; // R19
          o_flash.wdata <= latch_rdata;
          widx_reg <= widx_reg + 5'h01;
          if (widx_reg == `PFSA_LAST_LATCH) begin
            state_reg <= pfsa_pkg::ST_WAIT;
          end
        end
        pfsa_pkg::ST_WAIT: begin
          if (tmr_done) begin
            o_core_stall <= 1'b0; // R26
            state_reg <= pfsa_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Latches load in latch-only mode and blank after a row program only.
  pfsa_write_latches u_latches (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_load(go_latch && !i_seq_disturb), // R21
    .i_idx(adr_reg[4:0]), // R19
    .i_data(data_reg),
    .i_blank_all(op_end && is_prog_reg), // R20 R18
    .i_rd_idx(widx_reg),
    .o_rd_data(latch_rdata)
  );

  pfsa_op_timer #(.CYCLES(OP_CYCLES)) u_timer (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_start(tmr_start), // R26
    .o_done(tmr_done)
  );

  // Checks on the controller's own behaviour.
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  sequence s_rd_start;
    (state_reg == pfsa_pkg::ST_IDLE) && go_rd && rd_valid;
  endsequence
  sequence s_rd_finish;
    ##3 (!ctrl_reg[`PFSA_CTRL_RD] && !o_core_stall &&
         data_reg == $past(i_fl_rdata));
  endsequence

  a_reg_read_done: assert property (s_rd_start |-> s_rd_finish) // R7 R9
    else $error("register read did not finish in three cycles");
  a_ind_flash_addr: assert property ((state_reg == pfsa_pkg::ST_IDLE) &&
      i_ind.req && !i_ind.store && i_ind.ptr[15] && !go_wr && !go_rd
      |=> o_flash.rd && o_flash.addr == $past(i_ind.ptr[14:0])) // R1
    else $error("indirect flash read used wrong address");
  a_ind_port_zero: assert property ((state_reg == pfsa_pkg::ST_IDLE) &&
      i_ind.req && !i_ind.store && ptr_port && !go_wr && !go_rd
      |=> o_ind_valid && o_ind_data == 8'h00) // R2
    else $error("data port read did not return zero");
  a_ind_resume: assert property (o_flash.rd && ind_src_reg
      |-> ##2 o_ind_valid && !o_core_stall) // R3
    else $error("indirect read did not resume the core");
  a_store_ro: assert property ((state_reg == pfsa_pkg::ST_IDLE) &&
      i_ind.req && i_ind.store |=> !o_flash.rd && !o_core_stall) // R4
    else $error("indirect store started an access");
  a_unlock_gate: assert property ($rose(o_core_stall) &&
      (state_reg == pfsa_pkg::ST_WAIT || state_reg == pfsa_pkg::ST_PROG)
      |-> $past(key_reg) == pfsa_pkg::KEY_TWO) // R10 R11
    else $error("operation started without unlock");
  a_protect_block: assert property (wr_err |=>
      !ctrl_reg[`PFSA_CTRL_WR] && ctrl_reg[`PFSA_CTRL_WRITE_ERROR_FLAG] &&
      state_reg == pfsa_pkg::ST_IDLE) // R16 R5
    else $error("protected write was not refused");
  a_break_error: assert property (seq_break |=>
      ctrl_reg[`PFSA_CTRL_WRITE_ERROR_FLAG] && state_reg == pfsa_pkg::ST_IDLE) // R24
    else $error("broken unlock did not flag an error");
  a_done_flag: assert property (op_end |=> stat_done_reg &&
      !o_core_stall ##1 (o_done_irq == stat_ie_reg)) // R17
    else $error("completion flag or interrupt wrong");
  a_latch_blank: assert property (op_end && is_prog_reg
      |=> latch_rdata == `PFSA_BLANK_WORD) // R20
    else $error("latches not blank after programming");
  a_invalid_zero: assert property (go_rd && !rd_valid
      |=> data_reg == 14'h0 && !ctrl_reg[`PFSA_CTRL_RD]) // R25
    else $error("invalid read did not clear data");
  a_erase_keep: assert property (o_flash.erase |->
      $stable(ctrl_reg[`PFSA_CTRL_WRITE_ENABLE_BIT]) && o_core_stall) // R18 R12
    else $error("erase changed write enable or did not stall");
endmodule // pfsa_ctrl

// ---- core/pfsa_defs.svh ----
// Purpose: Offsets, field positions, reset values and timing for the
//          program flash self-access controller.
// Assumes: 20 MHz core clock, APB register bus with byte addresses.
// Notes:   Definitions only.
`ifndef PFSA_DEFS_SVH
`define PFSA_DEFS_SVH

// Register byte offsets.
`define PFSA_OFF_ADDR 8'h00
`define PFSA_OFF_DATA 8'h04
`define PFSA_OFF_CTRL 8'h08
`define PFSA_OFF_KEY 8'h0c
`define PFSA_OFF_STAT 8'h10

// Control register field positions.
`define PFSA_CTRL_RD 0
`define PFSA_CTRL_WR 1
`define PFSA_CTRL_WRITE_ENABLE_BIT 2
`define PFSA_CTRL_WRITE_ERROR_FLAG 3
`define PFSA_CTRL_FREE 4
`define PFSA_CTRL_LATCH_ONLY_MODE 5
`define PFSA_CTRL_REGS 6

// Status register field positions.
`define PFSA_STAT_DONE 0
`define PFSA_STAT_IE 1

// Reset values.
`define PFSA_RST_CTRL 7'h00
`define PFSA_RST_ADDR 15'h0000
`define PFSA_RST_DATA 14'h0000

// Unlock keys, blank latch value and pointer decode.
`define PFSA_KEY_FIRST 8'h55
`define PFSA_KEY_SECOND 8'haa
`define PFSA_BLANK_WORD 14'h3fff
`define PFSA_PTR_FLASH_BIT 15
`define PFSA_IND_PORT0 16'h0000
`define PFSA_IND_PORT1 16'h0001
`define PFSA_LAST_LATCH 5'h1f

// Timing: clock rate and program or erase duration in microseconds.
`define PFSA_CLK_MHZ 20
`define PFSA_T_OP_US 2000

`endif

// ---- core/pfsa_pkg.sv ----
// Purpose: Types shared by the program flash self-access controller.
// Assumes: Constants come from pfsa_defs.svh.
// Notes:   Types only.
package pfsa_pkg;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RD_ISSUE, ST_RD_TAKE, ST_PROG, ST_WAIT
  } pfsa_state_e;

  typedef enum logic [1:0] {KEY_NONE, KEY_ONE, KEY_TWO} pfsa_key_e;

  // Request to the flash array; prog is a per-word strobe.
  typedef struct packed {
    logic rd;
    logic erase;
    logic prog;
    logic [14:0] addr;
    logic [13:0] wdata;
  } pfsa_flash_req_s;

  // Indirect access from the core through the pointer pair.
  typedef struct packed {
    logic req;
    logic store;
    logic [15:0] ptr;
  } pfsa_ind_req_s;

endpackage

// ---- core/pfsa_write_latches.sv ----
// Purpose: The 32 row write latches of 14 bits each.
// Assumes: One load or one blank-all per cycle.
// Notes:   Blank-all wins over a load in the same cycle.
`timescale 1ns/100ps
`include "pfsa_defs.svh"
module pfsa_write_latches (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_load,
  input wire logic [4:0] i_idx,
  input wire logic [13:0] i_data,
  input wire logic i_blank_all,
  input wire logic [4:0] i_rd_idx,
  output logic [13:0] o_rd_data
);
  logic [13:0] latch_reg [32];

  // Each latch loads when addressed and returns to blank on a row write.
  for (genvar g = 0; g < 32; g++) begin : g_latch
    always_ff @(posedge i_sys_clk) begin
      if (i_rst || i_blank_all) begin
        latch_reg[g] <= `PFSA_BLANK_WORD;
      end else if (i_load && i_idx == 5'(g)) begin
        latch_reg[g] <= i_data;
      end
    end
  end

  assign o_rd_data = latch_reg[i_rd_idx];
endmodule // pfsa_write_latches

// ---- core/pfsa_op_timer.sv ----
// Purpose: Programming timer that holds an operation for a fixed time.
// Assumes: Start is a one-cycle pulse while idle.
// Notes:   Done pulses in the last counted cycle's following edge.
`timescale 1ns/100ps
module pfsa_op_timer #(
  parameter int CYCLES = 40000
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_start,
  output logic o_done
);
  logic [31:0] cnt_reg;

  // Down counter; done fires once when it reaches its last cycle.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cnt_reg <= 32'h0;
      o_done <= 1'b0;
    end else begin
      o_done <= (cnt_reg == 32'h1) && !i_start;
      if (i_start) begin
        cnt_reg <= 32'(CYCLES);
      end else if (cnt_reg != 32'h0) begin
        cnt_reg <= cnt_reg - 32'h1;
      end
    end
  end
endmodule // pfsa_op_timer

// ---- tb/pfsa_flash_model.sv ----
// Purpose: Flash array model that answers the controller's requests.
// Assumes: Read data is wanted only in the cycle after a read strobe.
// Notes:   Unwritten words hold an address pattern so reads are telling.
`timescale 1ns/100ps
module pfsa_flash_model (
  input wire logic i_sys_clk,
  input wire pfsa_pkg::pfsa_flash_req_s i_req,
  output logic [13:0] o_rdata
);
  logic [13:0] mem [int];

  initial o_rdata = 14'h0000;

  // Erase blanks a whole row and programming overwrites one word.
  // Outside the answer cycle the data toggles, so stale data never passes.
  always @(posedge i_sys_clk) begin
    if (i_req.erase) begin
      for (int k = 0; k < 32; k++) begin
        mem[{i_req.addr[14:5], 5'(k)}] = 14'h3fff;
      end
    end
    if (i_req.prog) begin
      mem[i_req.addr] = i_req.wdata;
    end
    if (i_req.rd) begin
      o_rdata <= mem.exists(i_req.addr) ? mem[i_req.addr] :
                 i_req.addr[13:0] ^ 14'h2a5a;
    end else begin
      o_rdata <= ~o_rdata;
    end
  end
endmodule // pfsa_flash_model

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for the flash self-access controller.
// Assumes: The operation time is shortened to 20 cycles.
// Notes:   Reset values run from a table; flash flows follow by hand.
`timescale 1ns/100ps
`include "pfsa_defs.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
  n_mismatch++; $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); \
  end end
module tb_top;
  localparam int OP = 20;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic e;} pfsa_row_s;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic err;
  logic pslverr;
  pfsa_pkg::pfsa_ind_req_s ind = '0;
  logic [7:0] ind_data;
  logic ind_valid;
  logic stall;
  logic disturb = 1'b0;
  logic wp = 1'b0;
  pfsa_pkg::pfsa_flash_req_s flash;
  logic [13:0] fl_rdata;
  logic done_irq;
  int n_mismatch = 0;
  int checks_done = 0;
  int ops = 0;
  pfsa_row_s rows [6] = '{'{`PFSA_OFF_ADDR, 32'h0, 1'b0},
    '{`PFSA_OFF_DATA, 32'h0, 1'b0}, '{`PFSA_OFF_CTRL, 32'h0, 1'b0},
    '{`PFSA_OFF_KEY, 32'h0, 1'b0}, '{`PFSA_OFF_STAT, 32'h0, 1'b0},
    '{8'h14, 32'h0, 1'b1}};

  pfsa_ctrl #(.OP_CYCLES(OP)) i_pfsa_ctrl (.i_sys_clk(clk), .i_rst(rst),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_ind(ind), .o_ind_data(ind_data),
    .o_ind_valid(ind_valid), .o_core_stall(stall), .i_seq_disturb(disturb),
    .i_write_protect(wp), .o_flash(flash), .i_fl_rdata(fl_rdata),
    .o_done_irq(done_irq));

  pfsa_flash_model i_pfsa_flash_model (.i_sys_clk(clk), .i_req(flash),
    .o_rdata(fl_rdata));

  always #25 clk = ~clk;

  // Counts memory-changing strobes so refused operations can be seen.
  always @(posedge clk) begin
    if (!rst && (flash.erase || flash.prog)) ops <= ops + 1;
  end

  task automatic finish_test();
    $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One transfer; an idle cycle first keeps psel from being driven twice.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      finish_test();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_op(output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (stall !== 1'b0 && n < 200);
    if (n >= 200) begin
      n_mismatch++;
      finish_test();
    end
  endtask

  // Unlock and start; brk 1 slips in a bus write, brk 2 raises a disturbance.
  task automatic op(input logic [31:0] a, input logic [31:0] c,
                    input int brk, output int n);
    logic [31:0] q;
    apb(1, `PFSA_OFF_ADDR, a, q);
    apb(1, `PFSA_OFF_CTRL, c, q);
    apb(1, `PFSA_OFF_KEY, 32'h55, q);
    if (brk == 1) apb(1, `PFSA_OFF_ADDR, a, q);
    if (brk == 2) disturb <= 1'b1;
    apb(1, `PFSA_OFF_KEY, 32'haa, q);
    disturb <= 1'b0;
    if (brk != 0) begin
      apb(0, `PFSA_OFF_CTRL, 32'h0, q);
      `CHK(q[3], 1'b1);
    end
    apb(1, `PFSA_OFF_CTRL, c | 32'h2, q);
    wait_op(n);
  endtask

  task automatic fread(input logic [31:0] a, input logic [31:0] c,
                       output logic [31:0] q);
    int n;
    apb(1, `PFSA_OFF_ADDR, a, q);
    apb(1, `PFSA_OFF_CTRL, c, q);
    wait_op(n);
    apb(0, `PFSA_OFF_DATA, 32'h0, q);
  endtask

  task automatic ind_rd(input logic st, input logic [15:0] p,
                        output logic [7:0] q, output int n);
    @(posedge clk);
    ind <= '{1'b1, st, p};
    @(posedge clk);
    ind <= '0;
    n = 0;
    while (ind_valid !== 1'b1 && n < 8) begin
      @(posedge clk);
      n++;
    end
    q = ind_data;
  endtask

  // Reset values first, then reads, indirect reads and the write flows.
  initial begin
    logic [31:0] q;
    logic [7:0] b;
    int n;
    int base;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      apb(0, rows[i].a, 32'h0, q);
      `CHK(q, rows[i].d);
      `CHK(err, rows[i].e);
    end
    fread(32'h0123, 32'h1, q);
    `CHK(q[13:0], 14'h0123 ^ 14'h2a5a);
    apb(0, `PFSA_OFF_CTRL, 32'h0, q);
    `CHK(q[0], 1'b0);
    apb(1, `PFSA_OFF_DATA, 32'h1111, q);
    fread(32'h0004, 32'h41, q);
    `CHK(q, 32'h0);
    ind_rd(1'b0, 16'h8123, b, n);
    `CHK(b, 8'h79);
    `CHK(n, 3);
    ind_rd(1'b0, 16'h0001, b, n);
    `CHK(b, 8'h00);
    base = ops;
    ind_rd(1'b1, 16'h8123, b, n);
    `CHK(n, 8);
    `CHK(ops - base, 0);
    // Latch load, erase of the row, then programming of the row.
    apb(1, `PFSA_OFF_DATA, 32'h1234, q);
    op(32'h0043, 32'h24, 0, n);
    `CHK(ops - base, 0);
    op(32'h0040, 32'h14, 0, n);
    `CHK(n >= OP, 1'b1);
    `CHK(ops - base, 1);
    apb(0, `PFSA_OFF_CTRL, 32'h0, q);
    `CHK(q[2:1], 2'b10);
    apb(0, `PFSA_OFF_STAT, 32'h0, q);
    `CHK(q[0], 1'b1);
    apb(1, `PFSA_OFF_STAT, 32'h2, q);
    repeat (2) @(posedge clk);
    `CHK(done_irq, 1'b1);
    op(32'h0040, 32'h04, 0, n);
    `CHK(ops - base, 33);
    fread(32'h0043, 32'h1, q);
    `CHK(q[13:0], 14'h1234);
    fread(32'h0044, 32'h1, q);
    `CHK(q[13:0], 14'h3fff);
    apb(1, `PFSA_OFF_DATA, 32'h0f0f, q);
    op(32'h0064, 32'h24, 0, n);
    op(32'h0060, 32'h04, 0, n);
    fread(32'h0063, 32'h1, q);
    `CHK(q[13:0], 14'h3fff);
    fread(32'h0064, 32'h1, q);
    `CHK(q[13:0], 14'h0f0f);
    // Broken unlocks and a protected target must change nothing.
    for (int k = 1; k <= 3; k++) begin
      wp <= (k == 3);
      base = ops;
      op(32'h0040, 32'h14, k % 3, n);
      `CHK(ops - base, 0);
      apb(0, `PFSA_OFF_CTRL, 32'h0, q);
      `CHK(q[3:1], {k == 3, 2'b10});
    end
    // A one-cycle reset in the middle of an erase must leave the error flag.
    wp <= 1'b0;
    apb(1, `PFSA_OFF_KEY, 32'h55, q);
    apb(1, `PFSA_OFF_KEY, 32'haa, q);
    apb(1, `PFSA_OFF_CTRL, 32'h16, q);
    repeat (4) @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    apb(0, `PFSA_OFF_CTRL, 32'h0, q);
    `CHK(q, 32'h8);
    `CHK(stall, 1'b0);
    finish_test();
  end
endmodule // tb_top
